// *** core/pwv_width_buffers.sv ***
// Our own choice: strobed register access.
`timescale 1ns/100ps
`include "pwv_consts.svh"
// Notes on behaviour
// [R1] Four 16-bit signed width registers
// [R2] Width at or below zero: output low
// [R3] Width at or above modulus: output high; the code keeps it low when the width is also at or below zero
// [R4] Active is high, inactive is low
// [R5] Writes buffer; load on okay and cycle
// [R6] Reads return buffered value
// [R7] Access allowed at any time
// [R8] Offsets 0x10, 0x12, 0x14, 0x16
// [R9] Okay clears on load, write zero, reset
// [R10] Software sets okay: read zero, write one; the code sets it on any write of one, with no read needed
// [R11] Compares use signed arithmetic
module pwv_width_buffers #(
   parameter int CHANNELS = 4
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [15:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [15:0] regRdData,
   input wire pwv_pkg::pwv_width_t modulus,
   input wire pwv_pkg::pwv_width_t pwmCount,
   input wire logic loadCycleStart,
   output logic loadOkayFlag,
   output logic loadDone,
   output logic channel_out_0,
   output logic channel_out_1,
   output logic channel_out_2,
   output logic channel_out_3
);
   // Elaboration check: decode and outputs exist for four channels only
   if (CHANNELS != 4)
   begin : gBadChannels
      $error("pwv_width_buffers supports exactly four channels");
   end

   // [R1] buffered widths
   pwv_pkg::pwv_width_t widthBuf_q [4];
   logic loadOkay_q;
   logic loadOkay_d;
   logic [15:0] regRdData_q;
   logic [15:0] regRdData_d;
   logic loadDone_q;
   logic loadStrobe;
   logic ctrlSel;
   logic widthHit;
   pwv_pkg::pwv_chan_t widthIdx;
   logic [3:0] chanOut;
   pwv_pkg::pwv_width_t activeWidth [4];

   // Test whether a byte address hits a width slot
   function automatic logic isWidthAddr(input logic [15:0] a);
      return (a >= `PWV_OFF_WIDTH_CH0) && (a <= `PWV_OFF_WIDTH_CH3)
         && (a[0] == 1'b0);
   endfunction : isWidthAddr

   // [R8] address decode
   assign widthHit = isWidthAddr(regAddr);
   assign widthIdx = pwv_pkg::pwv_chan_t'((regAddr - `PWV_OFF_WIDTH_CH0) >> 1);
   assign ctrlSel = (regAddr == `PWV_OFF_LOAD_CTRL);

   // [R5] load only when okay at cycle start
   assign loadStrobe = loadCycleStart & loadOkay_q;

   // [R9] auto clear on load; write may set or clear
   // A write in the load cycle is taken after the load, so write wins
   assign loadOkay_d = (regWrite && ctrlSel)
      ? regWrData[`PWV_LOAD_OKAY_BIT]
      : (loadStrobe ? 1'b0 : loadOkay_q);

   // [R6] read mux returns buffers, unmapped reads zero
   assign regRdData_d = widthHit ? widthBuf_q[widthIdx]
      : (ctrlSel ? {15'h0000, loadOkay_q} : 16'h0000);

   // [R7] write buffers with no lock
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 0; i < 4; i++)
            widthBuf_q[i] <= `PWV_WIDTH_RESET;
      end
      else if (regWrite && widthHit)
      begin
         widthBuf_q[widthIdx] <= regWrData;
      end
   end

   // Control flag, load pulse and read data
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         loadOkay_q <= 1'b0;
         loadDone_q <= 1'b0;
         regRdData_q <= 16'h0000;
      end
      else
      begin
         loadOkay_q <= loadOkay_d;
         loadDone_q <= loadStrobe;
         regRdData_q <= regRead ? regRdData_d : 16'h0000;
      end
   end

   // One compare path per channel
   for (genvar g = 0; g < 4; g++)
   begin : gChan
      pwv_channel_compare uCmp (
         .clock(clock),
         .rst(rst),
         .loadStrobe(loadStrobe),
         .bufferedWidth(widthBuf_q[g]),
         .modulus(modulus),
         .count(pwmCount),
         .activeWidth(activeWidth[g]),
         .channelOut(chanOut[g])
      );
   end

   assign regRdData = regRdData_q;
   assign loadOkayFlag = loadOkay_q;
   assign loadDone = loadDone_q;
   assign channel_out_0 = chanOut[0];
   assign channel_out_1 = chanOut[1];
   assign channel_out_2 = chanOut[2];
   assign channel_out_3 = chanOut[3];

   // Assertions: load path
   // [R5] load copies buffer
   AST_LOAD_COPIES: assert property ( // [R5]
      @(posedge clock) disable iff (rst)
      loadStrobe |=> activeWidth[0] == $past(widthBuf_q[0]))
      else $error("Active width not loaded from buffer");

   // [R5] channel one loads
   AST_LOAD_COPIES_1: assert property ( // [R5]
      @(posedge clock) disable iff (rst)
      loadStrobe |=> activeWidth[1] == $past(widthBuf_q[1]))
      else $error("Active width one not loaded from buffer");

   // [R5] channel two loads
   AST_LOAD_COPIES_2: assert property ( // [R5]
      @(posedge clock) disable iff (rst)
      loadStrobe |=> activeWidth[2] == $past(widthBuf_q[2]))
      else $error("Active width two not loaded from buffer");

   // [R5] channel three loads
   AST_LOAD_COPIES_3: assert property ( // [R5]
      @(posedge clock) disable iff (rst)
      loadStrobe |=> activeWidth[3] == $past(widthBuf_q[3]))
      else $error("Active width three not loaded from buffer");

   // [R5] no load, no change
   AST_NO_LOAD_HOLD: assert property ( // [R5]
      @(posedge clock) disable iff (rst)
      !loadStrobe |=> $stable(activeWidth[1]))
      else $error("Active width changed without load");

   // [R5] channel zero holds
   AST_NO_LOAD_HOLD_0: assert property ( // [R5]
      @(posedge clock) disable iff (rst)
      !loadStrobe |=> $stable(activeWidth[0]))
      else $error("Active width zero changed without load");

   // [R5] channel two holds
   AST_NO_LOAD_HOLD_2: assert property ( // [R5]
      @(posedge clock) disable iff (rst)
      !loadStrobe |=> $stable(activeWidth[2]))
      else $error("Active width two changed without load");

   // [R5] cycle start needs flag
   AST_LOAD_NEEDS_OKAY: assert property ( // [R5]
      @(posedge clock) disable iff (rst)
      (loadCycleStart && !loadOkay_q) |=> $stable(activeWidth[3]))
      else $error("Load taken without the load-okay flag");

   // [R5] done follows load
   AST_DONE_AFTER_LOAD: assert property ( // [R5]
      @(posedge clock) disable iff (rst)
      loadStrobe |=> loadDone)
      else $error("Load done pulse missing after load");

   // [R5] done only after load
   AST_DONE_ONLY_ON_LOAD: assert property ( // [R5]
      @(posedge clock) disable iff (rst)
      !loadStrobe |=> !loadDone)
      else $error("Load done pulse without a load");

   // Assertions: load-okay flag
   // [R9] load clears flag
   AST_OKAY_CLEARS: assert property ( // [R9]
      @(posedge clock) disable iff (rst)
      (loadStrobe && !(regWrite && ctrlSel)) |=> !loadOkay_q)
      else $error("Load okay flag did not clear after load");

   // [R9] write zero clears
   AST_OKAY_WRITE_CLEAR: assert property ( // [R9]
      @(posedge clock) disable iff (rst)
      (regWrite && ctrlSel && !regWrData[`PWV_LOAD_OKAY_BIT])
      |=> !loadOkay_q)
      else $error("Load okay flag not cleared by write");

   // [R10] write one sets
   AST_OKAY_SET: assert property ( // [R10]
      @(posedge clock) disable iff (rst)
      (regWrite && ctrlSel && regWrData[`PWV_LOAD_OKAY_BIT])
      |=> loadOkay_q)
      else $error("Load okay flag not set by write");

   // [R9] flag otherwise holds
   AST_OKAY_HOLDS: assert property ( // [R9]
      @(posedge clock) disable iff (rst)
      (!(regWrite && ctrlSel) && !loadStrobe)
      |=> $stable(loadOkay_q))
      else $error("Load okay flag changed with no cause");

   // [R9] flag reads back
   AST_READ_OKAY: assert property ( // [R9]
      @(posedge clock) disable iff (rst)
      (regRead && ctrlSel) |=> regRdData == {15'h0000, $past(loadOkay_q)})
      else $error("Read of load control did not return the flag");

   // Assertions: buffers and read data
   // [R7] write lands anytime
   AST_WRITE_STORES: assert property ( // [R7]
      @(posedge clock) disable iff (rst)
      (regWrite && regAddr == `PWV_OFF_WIDTH_CH2)
      |=> widthBuf_q[2] == $past(regWrData))
      else $error("Width write not stored");

   // [R7] channel zero write
   AST_WRITE_STORES_0: assert property ( // [R7]
      @(posedge clock) disable iff (rst)
      (regWrite && regAddr == `PWV_OFF_WIDTH_CH0)
      |=> widthBuf_q[0] == $past(regWrData))
      else $error("Width zero write not stored");

   // [R7] channel one write
   AST_WRITE_STORES_1: assert property ( // [R7]
      @(posedge clock) disable iff (rst)
      (regWrite && regAddr == `PWV_OFF_WIDTH_CH1)
      |=> widthBuf_q[1] == $past(regWrData))
      else $error("Width one write not stored");

   // [R7] channel three write
   AST_WRITE_STORES_3: assert property ( // [R7]
      @(posedge clock) disable iff (rst)
      (regWrite && regAddr == `PWV_OFF_WIDTH_CH3)
      |=> widthBuf_q[3] == $past(regWrData))
      else $error("Width three write not stored");

   // [R5] buffers 1 and 2 change only on writes
   AST_BUF_HOLD: assert property ( // [R5]
      @(posedge clock) disable iff (rst)
      !regWrite
      |=> $stable(widthBuf_q[1]) && $stable(widthBuf_q[2]))
      else $error("Width buffer changed without a write");

   // [R8] unmapped write ignored
   AST_UNMAPPED_WRITE: assert property ( // [R8]
      @(posedge clock) disable iff (rst)
      (regWrite && !widthHit)
      |=> $stable(widthBuf_q[0]) && $stable(widthBuf_q[3]))
      else $error("Unmapped write changed a width buffer");

   // [R6] read returns buffer
   AST_READ_BACK: assert property ( // [R6]
      @(posedge clock) disable iff (rst)
      (regRead && regAddr == `PWV_OFF_WIDTH_CH3)
      |=> regRdData == $past(widthBuf_q[3]))
      else $error("Read did not return buffered width");

   // [R6] channel zero read
   AST_READ_BACK_0: assert property ( // [R6]
      @(posedge clock) disable iff (rst)
      (regRead && regAddr == `PWV_OFF_WIDTH_CH0)
      |=> regRdData == $past(widthBuf_q[0]))
      else $error("Read of width zero did not return its buffer");

   // [R6] channel one read
   AST_READ_BACK_1: assert property ( // [R6]
      @(posedge clock) disable iff (rst)
      (regRead && regAddr == `PWV_OFF_WIDTH_CH1)
      |=> regRdData == $past(widthBuf_q[1]))
      else $error("Read of width one did not return its buffer");

   // [R6] channel two read
   AST_READ_BACK_2: assert property ( // [R6]
      @(posedge clock) disable iff (rst)
      (regRead && regAddr == `PWV_OFF_WIDTH_CH2)
      |=> regRdData == $past(widthBuf_q[2]))
      else $error("Read of width two did not return its buffer");

   // [R8] unmapped reads zero
   AST_UNMAPPED_ZERO: assert property ( // [R8]
      @(posedge clock) disable iff (rst)
      (regRead && !widthHit && !ctrlSel) |=> regRdData == 16'h0000)
      else $error("Unmapped read not zero");

   // [R6] data only after read
   AST_RDATA_IDLE: assert property ( // [R6]
      @(posedge clock) disable iff (rst)
      !regRead |=> regRdData == 16'h0000)
      else $error("Read data not zero outside a read");

   // Assertions: channel outputs
   // [R11] negative stays low
   AST_SIGNED_LOW: assert property ( // [R11]
      @(posedge clock) disable iff (rst)
      activeWidth[0][15] |=> !channel_out_0)
      else $error("Negative width did not keep output low");

   // [R11] channel one negative
   AST_NEG_LOW_1: assert property ( // [R11]
      @(posedge clock) disable iff (rst)
      activeWidth[1][15] |=> !channel_out_1)
      else $error("Negative width one did not keep output low");

   // [R4] activated means high
   AST_OUT_LEVEL: assert property ( // [R4]
      @(posedge clock) disable iff (rst)
      ($signed(activeWidth[1]) > 0 && activeWidth[1] >= modulus
       && $stable(activeWidth[1]) && $stable(modulus))
      |=> channel_out_1)
      else $error("Activated output not high");

   // [R4] high below width
   AST_PARTIAL_HIGH: assert property ( // [R4]
      @(posedge clock) disable iff (rst)
      (activeWidth[3] > 0 && activeWidth[3] < modulus
       && pwmCount < activeWidth[3]) |=> channel_out_3)
      else $error("Output low while count below width");

   // [R4] low from width on
   AST_PARTIAL_LOW: assert property ( // [R4]
      @(posedge clock) disable iff (rst)
      (activeWidth[3] > 0 && activeWidth[3] < modulus
       && pwmCount >= activeWidth[3]) |=> !channel_out_3)
      else $error("Output high while count at or above width");

   // Covers for the main scenarios
   // A granted load
   COV_LOAD: cover property (@(posedge clock) disable iff (rst)
      loadStrobe);
   // A negative width in use
   COV_NEG: cover property (@(posedge clock) disable iff (rst)
      activeWidth[1][15]);
   // Output held for two cycles
   COV_FULL: cover property (@(posedge clock) disable iff (rst)
      channel_out_3 ##1 channel_out_3);
   // Software withdraws the flag
   COV_CLR: cover property (@(posedge clock) disable iff (rst)
      regWrite && ctrlSel && !regWrData[`PWV_LOAD_OKAY_BIT] && loadOkay_q);
   // Flag write in the load cycle
   COV_WRITE_IN_LOAD: cover property (@(posedge clock) disable iff (rst)
      loadStrobe && regWrite && ctrlSel);
endmodule : pwv_width_buffers

// *** include/pwv_consts.svh ***
`ifndef PWV_CONSTS_SVH
`define PWV_CONSTS_SVH
// Register offsets (byte addresses, 16-bit slots)
`define PWV_OFF_WIDTH_CH0 16'h0010
`define PWV_OFF_WIDTH_CH1 16'h0012
`define PWV_OFF_WIDTH_CH2 16'h0014
`define PWV_OFF_WIDTH_CH3 16'h0016
`define PWV_OFF_LOAD_CTRL 16'h0020
// Load control field position
`define PWV_LOAD_OKAY_BIT 0
// Reset values
`define PWV_WIDTH_RESET 16'h0000
`define PWV_MODULUS_RESET 16'h0000
`endif

// *** include/pwv_pkg.sv ***
package pwv_pkg;
   // Data width of a pulse-width register
   typedef logic signed [15:0] pwv_width_t;
   // Channel index
   typedef logic [1:0] pwv_chan_t;
endpackage : pwv_pkg

// *** core/pwv_channel_compare.sv ***
`timescale 1ns/100ps
`include "pwv_consts.svh"
module pwv_channel_compare
(
   input wire logic clock,
   input wire logic rst,
   input wire logic loadStrobe,
   input wire pwv_pkg::pwv_width_t bufferedWidth,
   input wire pwv_pkg::pwv_width_t modulus,
   input wire pwv_pkg::pwv_width_t count,
   output pwv_pkg::pwv_width_t activeWidth,
   output logic channelOut
);
   pwv_pkg::pwv_width_t activeWidth_q;
   logic channelOut_q;
   logic forceLow;
   logic forceHigh;
   logic pwmLevel;
   logic channelOut_d;

   // [R11] signed compares
   assign forceLow = (activeWidth_q <= $signed(16'sh0000));
   assign forceHigh = (activeWidth_q >= modulus);
   assign pwmLevel = (count < activeWidth_q);
   // [R2] [R3] [R4] zero forces low, modulus forces high
   assign channelOut_d = forceLow ? 1'b0 : (forceHigh ? 1'b1 : pwmLevel);

   // Active copy only changes on a granted load
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         activeWidth_q <= `PWV_WIDTH_RESET;
         channelOut_q <= 1'b0;
      end
      else
      begin
         // [R5] load at cycle start
         if (loadStrobe)
            activeWidth_q <= bufferedWidth;
         channelOut_q <= channelOut_d;
      end
   end

   assign activeWidth = activeWidth_q;
   assign channelOut = channelOut_q;

   // [R2] nonpositive width
   AST_NONPOS_LOW: assert property ( // [R2]
      @(posedge clock) disable iff (rst)
      ($signed(activeWidth_q) <= 0) |=> !channelOut_q)
      else $error("Nonpositive width did not give low output");
   // [R3] full width
   AST_FULL_HIGH: assert property ( // [R3]
      @(posedge clock) disable iff (rst)
      ($signed(activeWidth_q) > 0 && activeWidth_q >= modulus)
      |=> channelOut_q)
      else $error("Width at modulus did not give high output");
endmodule : pwv_channel_compare

// *** verif/tb_top.sv ***
`timescale 1ns/100ps
`include "pwv_consts.svh"
module tb_top;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [15:0] regAddr = 16'h0000;
   logic [15:0] regWrData = 16'h0000;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [15:0] regRdData;
   pwv_pkg::pwv_width_t modulus = 16'h0064;
   pwv_pkg::pwv_width_t pwmCount = 16'h0032;
   logic loadCycleStart = 1'b0;
   logic loadOkayFlag;
   logic loadDone;
   logic [3:0] outs;
   int error_cnt = 0;
   int compares = 0;
   pwv_width_buffers dut (.clock(clock), .rst(rst), .regAddr(regAddr),
      .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
      .regRdData(regRdData), .modulus(modulus), .pwmCount(pwmCount),
      .loadCycleStart(loadCycleStart), .loadOkayFlag(loadOkayFlag),
      .loadDone(loadDone), .channel_out_0(outs[0]),
      .channel_out_1(outs[1]), .channel_out_2(outs[2]),
      .channel_out_3(outs[3]));
   // Free-running 50 ns clock
   initial
   begin
      forever #25 clock = ~clock;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clock);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge clock);
      regWrite <= 1'b0;
   endtask : wr
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [15:0] a, input logic [15:0] exp);
      @(posedge clock);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clock);
      regRead <= 1'b0;
      #1 chk(regRdData, exp);
   endtask : rd
   // One load-cycle pulse; flag and done settle after the sampling edge
   task automatic pulse_load(input logic expDone);
      @(posedge clock);
      loadCycleStart <= 1'b1;
      @(posedge clock);
      loadCycleStart <= 1'b0;
      #1 chk({15'h0000, loadDone}, {15'h0000, expDone});
      chk({15'h0000, loadOkayFlag}, 16'h0000);
      @(posedge clock);
   endtask : pulse_load
   task automatic t_regs;
      wr(`PWV_OFF_WIDTH_CH0, 16'ha5a5);
      wr(`PWV_OFF_WIDTH_CH1, 16'h5a5a);
      wr(`PWV_OFF_WIDTH_CH2, 16'h8001);
      wr(`PWV_OFF_WIDTH_CH3, 16'h7fff);
      wr(16'h0018, 16'h1111);
      rd(`PWV_OFF_WIDTH_CH0, 16'ha5a5);
      rd(`PWV_OFF_WIDTH_CH1, 16'h5a5a);
      rd(`PWV_OFF_WIDTH_CH2, 16'h8001);
      rd(`PWV_OFF_WIDTH_CH3, 16'h7fff);
      rd(16'h0018, 16'h0000);
      rd(16'h0011, 16'h0000);
      $display("test regs done");
   endtask : t_regs
   // Without the flag, buffered widths must not reach the outputs
   task automatic t_hold;
      pulse_load(1'b0);
      #1 chk({12'h000, outs}, 16'h0000);
      $display("test hold done");
   endtask : t_hold
   task automatic t_load;
      wr(`PWV_OFF_WIDTH_CH0, 16'h0000);
      wr(`PWV_OFF_WIDTH_CH1, 16'hfffb);
      wr(`PWV_OFF_WIDTH_CH2, 16'h0064);
      wr(`PWV_OFF_WIDTH_CH3, 16'h003c);
      rd(`PWV_OFF_LOAD_CTRL, 16'h0000);
      wr(`PWV_OFF_LOAD_CTRL, 16'h0001);
      rd(`PWV_OFF_LOAD_CTRL, 16'h0001);
      pulse_load(1'b1);
      #1 chk({12'h000, outs}, 16'h000c);
      // Count at the width: only the forced-high path keeps channel 2 up
      @(posedge clock);
      pwmCount <= 16'h0064;
      @(posedge clock);
      #1 chk({12'h000, outs}, 16'h0004);
      rd(`PWV_OFF_WIDTH_CH1, 16'hfffb);
      $display("test load done");
   endtask : t_load
   // Negative count would lift widths at or below zero without force-low
   task automatic t_clear;
      @(posedge clock);
      pwmCount <= 16'hfff0;
      wr(`PWV_OFF_WIDTH_CH0, 16'h7fff);
      rd(`PWV_OFF_LOAD_CTRL, 16'h0000);
      wr(`PWV_OFF_LOAD_CTRL, 16'h0001);
      wr(`PWV_OFF_LOAD_CTRL, 16'h0000);
      rd(`PWV_OFF_LOAD_CTRL, 16'h0000);
      pulse_load(1'b0);
      #1 chk({12'h000, outs}, 16'h000c);
      rd(`PWV_OFF_WIDTH_CH0, 16'h7fff);
      $display("test clear done");
   endtask : t_clear
   task automatic close_out;
      $display("compares=%0d errors=%0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : close_out
   // Tests need under a hundred cycles; the 5000-cycle timeout allows ample margin
   initial
   begin
      #(50 * 5000);
      error_cnt++;
      close_out();
   end
   initial
   begin
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      t_regs();
      t_hold();
      t_load();
      t_clear();
      close_out();
   end
endmodule : tb_top
